//--- rtl/watchdog_pkg.sv
/*
  constants for the watchdog, write window, low-voltage and stop-recovery block.
  assumes a 100 MHz system clock and a 32-bit classic wishbone register bus.
*/
package watchdog_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOW_VOLTAGE_CONTROL = 8'h01;
  localparam logic [7:0] IDX_BLOCK_STATUS = 8'h02;
  localparam logic [7:0] IDX_STOP_RECOVERY = 8'h0b;
  localparam logic [7:0] IDX_WATCHDOG_MODE = 8'h0f;
  localparam logic [7:0] ADDR_LOW_VOLTAGE_CONTROL = 8'(IDX_LOW_VOLTAGE_CONTROL * 4);
  localparam logic [7:0] ADDR_BLOCK_STATUS = 8'(IDX_BLOCK_STATUS * 4);
  localparam logic [7:0] ADDR_STOP_RECOVERY = 8'(IDX_STOP_RECOVERY * 4);
  localparam logic [7:0] ADDR_WATCHDOG_MODE = 8'(IDX_WATCHDOG_MODE * 4);

  // watchdog mode fields
  localparam int MODE_TSEL_LSB = 0;
  localparam int MODE_HALT_BIT = 2;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_SRC_BIT = 4;
  localparam logic [4:0] MODE_RESET = 5'h0d;

  // stop-recovery fields
  localparam int SR_DIV16_BIT = 0;
  localparam int SR_SRC_LSB = 2;
  localparam int SR_DELAY_BIT = 5;
  localparam int SR_LEVEL_BIT = 6;
  localparam int SR_FLAG_BIT = 7;
  localparam logic [6:0] SR_RESET = 7'h00;

  // status fields
  localparam int ST_LV_FLAG_BIT = 0;
  localparam int ST_RUNNING_BIT = 1;
  localparam int ST_WINDOW_BIT = 2;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WINDOW_CYCLES = 60;
  localparam int RESET_TIMER_CYCLES = 18;
  localparam int LV_SETTLE_NS = 20000;
  localparam int LV_SETTLE_CYCLES = (LV_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_TICK_NS = 10000;
  localparam int RC_TICK_CYCLES = RC_TICK_NS / CLK_PERIOD_NS;
  localparam int RC_TIMEOUT0_MS = 5;
  localparam int RC_TIMEOUT1_MS = 10;
  localparam int RC_TIMEOUT2_MS = 20;
  localparam int RC_TIMEOUT3_MS = 80;
  localparam int RC_TICKS0 = (RC_TIMEOUT0_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;
  localparam int RC_TICKS1 = (RC_TIMEOUT1_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;
  localparam int RC_TICKS2 = (RC_TIMEOUT2_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;
  localparam int RC_TICKS3 = (RC_TIMEOUT3_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;
  localparam int XTAL_TICKS0 = 256;
  localparam int XTAL_TICKS1 = 512;
  localparam int XTAL_TICKS2 = 1024;
  localparam int XTAL_TICKS3 = 4096;

  typedef enum logic [1:0] {
    WIN_ARMED = 2'b00,
    WIN_OPEN = 2'b01,
    WIN_CLOSED = 2'b10
  } window_state_t;
endpackage

//--- rtl/watchdog_stop_recovery.sv
/*
  watchdog timer with mode register writable only in a timed write window, reset timer,
  low-voltage reset and stop-recovery register, behind a classic wishbone slave.
  assumes all inputs synchronous to sys_clk; the core pulses refresh and first
  instruction for one cycle; the crystal pin is slower than half the system clock.
*/
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
module watchdog_stop_recovery
  import watchdog_pkg::*;
#(
  parameter int RcTickCycles = RC_TICK_CYCLES,
  parameter int RcTicks0 = RC_TICKS0,
  parameter int RcTicks1 = RC_TICKS1,
  parameter int RcTicks2 = RC_TICKS2,
  parameter int RcTicks3 = RC_TICKS3,
  parameter int LvSettleCycles = LV_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic refreshPulse,
  input wire logic firstInstruction,
  input wire logic haltMode,
  input wire logic stopMode,
  input wire logic stopRecovered,
  input wire logic crystalInputPin,
  input wire logic clearPulseOne_n,
  input wire logic clearPulseTwo_n,
  input wire logic lowVoltage,
  output logic globalReset_n,
  output logic watchdogExpired,
  output logic lowVoltageDetectEnable,
  output logic [2:0] recoverySource,
  output logic recoveryLevelHigh,
  output logic recoveryDelay,
  output logic clockDivide16
);
  localparam int CW = 13;
  localparam int RW = 12;

  initial begin
    if (RcTicks3 >= (1 << CW) || RcTicks0 < 1 || RcTickCycles < 2 ||
        RcTickCycles >= (1 << RW) || LvSettleCycles >= (1 << RW) || LvSettleCycles < 1) begin
      $error("watchdog_stop_recovery: parameter out of range");
    end
  end

  logic ackReg;
  logic [31:0] datReg;
  logic [4:0] modeReg;
  logic [6:0] recoveryReg;
  logic recoveryFlagReg;
  logic lvEnableReg;
  logic [RW-1:0] lvSettleReg;
  logic runningReg;
  logic [CW-1:0] countReg;
  logic [RW-1:0] rcDivReg;
  logic crystalPrevReg;
  logic clearOnePrevReg;
  logic clearTwoPrevReg;
  logic [4:0] resetTimerReg;
  logic expiredReg;
  logic globalResetReg;
  window_state_t windowReg;
  window_state_t windowNext;
  logic [5:0] windowCountReg;

  // bus decode
  wire busReq = wb_cyc_i && wb_stb_i && !ackReg;
  wire busWrite = busReq && wb_we_i && wb_sel_i[0];
  wire hitMode = wb_adr_i == ADDR_WATCHDOG_MODE;
  wire hitRecovery = wb_adr_i == ADDR_STOP_RECOVERY;
  wire hitLvControl = wb_adr_i == ADDR_LOW_VOLTAGE_CONTROL;
  wire hitStatus = wb_adr_i == ADDR_BLOCK_STATUS;
  wire windowOpen = windowReg == WIN_OPEN;
  wire modeWrite = busWrite && hitMode && windowOpen;
  wire recoveryWrite = busWrite && hitRecovery;
  wire lvWrite = busWrite && hitLvControl;
  wire lvFlagValid = lvEnableReg && (lvSettleReg == '0);
  wire [7:0] statusByte = {5'h00, windowOpen, runningReg, lvFlagValid && lowVoltage};
  wire [7:0] readByte = hitRecovery ? {recoveryFlagReg, 7'h00} :
                        hitLvControl ? {7'h00, lvEnableReg} :
                        hitStatus ? statusByte : 8'h00;

  // tick sources
  wire rcTick = rcDivReg == RW'(RcTickCycles - 1);
  wire crystalTick = crystalInputPin && !crystalPrevReg;
  wire srcTick = modeReg[MODE_SRC_BIT] ? crystalTick : rcTick;
  wire suspended = (haltMode && !modeReg[MODE_HALT_BIT]) ||
                   (stopMode && !modeReg[MODE_STOP_BIT]);
  wire countTick = runningReg && srcTick && !suspended;
  wire [1:0] tsel = modeReg[MODE_TSEL_LSB +: 2];
  wire [CW-1:0] xtalLimit = (tsel == 2'b00) ? CW'(XTAL_TICKS0) :
                            (tsel == 2'b01) ? CW'(XTAL_TICKS1) :
                            (tsel == 2'b10) ? CW'(XTAL_TICKS2) : CW'(XTAL_TICKS3);
  wire [CW-1:0] rcLimit = (tsel == 2'b00) ? CW'(RcTicks0) :
                          (tsel == 2'b01) ? CW'(RcTicks1) :
                          (tsel == 2'b10) ? CW'(RcTicks2) : CW'(RcTicks3);
  wire [CW-1:0] limit = modeReg[MODE_SRC_BIT] ? xtalLimit : rcLimit;
  wire terminal = countTick && (countReg == limit - CW'(1));
  wire clearRise = (clearPulseOne_n && !clearOnePrevReg) ||
                   (clearPulseTwo_n && !clearTwoPrevReg);
  wire startResetTimer = terminal || clearRise;
  wire resetNow = lowVoltage || startResetTimer || (resetTimerReg != '0);

  // wishbone slave, answer one cycle after request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackReg <= 1'b0;
      datReg <= 32'h0000_0000;
    end else begin
      ackReg <= busReq;
      datReg <= busReq ? {24'h000000, readByte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg <= MODE_RESET;
    end else if (expiredReg) begin
      modeReg <= MODE_RESET;
    end else if (modeWrite) begin
      modeReg <= wb_dat_i[4:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      recoveryReg <= SR_RESET;
    end else if (recoveryWrite) begin
      recoveryReg <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      recoveryFlagReg <= 1'b0;
    end else if (stopRecovered) begin
      recoveryFlagReg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lvEnableReg <= 1'b0;
      lvSettleReg <= '0;
    end else if (lvWrite) begin
      lvEnableReg <= wb_dat_i[0];
      lvSettleReg <= (wb_dat_i[0] && !lvEnableReg) ? RW'(LvSettleCycles) : lvSettleReg;
    end else if (lvSettleReg != '0) begin
      lvSettleReg <= lvSettleReg - RW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rcDivReg <= '0;
      crystalPrevReg <= 1'b0;
      clearOnePrevReg <= 1'b1;
      clearTwoPrevReg <= 1'b1;
    end else begin
      rcDivReg <= rcTick ? '0 : rcDivReg + RW'(1);
      crystalPrevReg <= crystalInputPin;
      clearOnePrevReg <= clearPulseOne_n;
      clearTwoPrevReg <= clearPulseTwo_n;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      runningReg <= 1'b0;
      countReg <= '0;
    end else if (terminal) begin
      runningReg <= 1'b0;
      countReg <= '0;
    end else if (refreshPulse) begin
      runningReg <= 1'b1;
      countReg <= '0;
    end else if (clearRise) begin
      countReg <= '0;
    end else if (countTick) begin
      countReg <= countReg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resetTimerReg <= '0;
      expiredReg <= 1'b0;
      globalResetReg <= 1'b0;
    end else begin
      resetTimerReg <= startResetTimer ? 5'(RESET_TIMER_CYCLES) :
                       (resetTimerReg != '0) ? resetTimerReg - 5'h01 : resetTimerReg;
      expiredReg <= terminal;
      globalResetReg <= resetNow;
    end
  end

  always_comb begin
    windowNext = windowReg;
    case (windowReg)
      WIN_ARMED: begin
        if (firstInstruction) begin
          windowNext = WIN_OPEN;
        end
      end
      WIN_OPEN: begin
        if (windowCountReg == 6'(WINDOW_CYCLES - 1)) begin
          windowNext = WIN_CLOSED;
        end
      end
      WIN_CLOSED: begin
        windowNext = WIN_CLOSED;
      end
      default: begin
        windowNext = WIN_ARMED;
      end
    endcase
    if (expiredReg || stopRecovered) begin
      windowNext = WIN_ARMED;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      windowReg <= WIN_ARMED;
      windowCountReg <= '0;
    end else begin
      windowReg <= windowNext;
      windowCountReg <= (windowNext == WIN_OPEN && windowReg == WIN_OPEN) ?
                        windowCountReg + 6'h01 : 6'h00;
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;
  assign globalReset_n = !globalResetReg;
  assign watchdogExpired = expiredReg;
  assign lowVoltageDetectEnable = lvEnableReg;
  assign recoverySource = recoveryReg[SR_SRC_LSB +: 3];
  assign recoveryLevelHigh = recoveryReg[SR_LEVEL_BIT];
  assign recoveryDelay = recoveryReg[SR_DELAY_BIT];
  assign clockDivide16 = recoveryReg[SR_DIV16_BIT];

  // assertions
  logic [6:0] openCountChk;
  logic [31:0] datPrevChk;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      openCountChk <= '0;
      datPrevChk <= 32'h0000_0000;
    end else begin
      openCountChk <= (windowReg == WIN_OPEN) ? openCountChk + 7'h01 : 7'h00;
      datPrevChk <= wb_dat_i;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_expiry_resets_core: assert property (
    terminal |=> expiredReg && !globalReset_n
  ) else $error("terminal count did not reset the core");
  chk_idle_until_refresh: assert property (
    !runningReg && !refreshPulse |=> countReg == '0 && !expiredReg
  ) else $error("watchdog counted before first refresh");
  chk_refresh_restarts: assert property (
    refreshPulse && !terminal |=> runningReg && countReg == '0
  ) else $error("refresh did not restart the count");
  chk_crystal_tap_limit: assert property (
    modeReg[MODE_SRC_BIT] && tsel == 2'b11 |-> limit == CW'(4096)
  ) else $error("crystal tap limit wrong");
  chk_halt_suspends: assert property (
    haltMode && !modeReg[MODE_HALT_BIT] && !refreshPulse && !clearRise
      |=> countReg == $past(countReg)
  ) else $error("count moved while suspended in halt");
  chk_window_sixty_cycles: assert property (
    openCountChk <= 7'(WINDOW_CYCLES)
  ) else $error("write window longer than sixty cycles");
  chk_closed_ignores_write: assert property (
    windowReg == WIN_CLOSED && !expiredReg |=> $stable(modeReg)
  ) else $error("mode changed after window closed");
  chk_mode_reads_zero: assert property (
    busReq && !wb_we_i && hitMode |=> wb_ack_o && wb_dat_o == 32'h0000_0000
  ) else $error("mode register read back");
  chk_reset_timer_hold: assert property (
    clearRise && !lowVoltage |=> !globalReset_n [*8]
  ) else $error("reset timer released early");
  chk_low_voltage_reset: assert property (
    lowVoltage |=> !globalReset_n
  ) else $error("low supply did not reset");
  chk_flag_settle: assert property (
    lvWrite && wb_dat_i[0] && !lvEnableReg |=> !lvFlagValid [*8]
  ) else $error("low-voltage flag valid too soon");
  chk_recovery_flag_sticky: assert property (
    recoveryFlagReg |=> recoveryFlagReg
  ) else $error("recovery flag cleared without power-on");
  chk_rc_tap_limit: assert property (
    !modeReg[MODE_SRC_BIT] && tsel == 2'b11 |-> limit == CW'(RcTicks3)
  ) else $error("rc tap limit wrong");
  chk_defaults_after_expiry: assert property (
    expiredReg |=> modeReg == MODE_RESET && windowReg == WIN_ARMED
  ) else $error("expiry did not restore mode defaults");
  chk_stop_suspends: assert property (
    stopMode && !modeReg[MODE_STOP_BIT] && !refreshPulse && !clearRise
      |=> countReg == $past(countReg)
  ) else $error("count moved while suspended in stop");
  chk_reserved_bits_dropped: assert property (
    modeWrite && !expiredReg |=> modeReg == datPrevChk[4:0]
  ) else $error("mode write not stored as five bits");
  chk_recovery_reads_flag: assert property (
    busReq && !wb_we_i && hitRecovery |=> wb_dat_o[6:0] == 7'h00
  ) else $error("recovery control bits read back");
  chk_recovery_fields: assert property (
    recoveryWrite |=> {recoveryLevelHigh, recoveryDelay, recoverySource} == datPrevChk[6:2]
  ) else $error("recovery fields not stored");
  chk_divide_select: assert property (
    recoveryWrite |=> clockDivide16 == datPrevChk[SR_DIV16_BIT]
  ) else $error("divide select not stored");
  chk_window_opens: assert property (
    windowReg == WIN_ARMED && firstInstruction && !expiredReg && !stopRecovered
      |=> windowOpen
  ) else $error("first instruction did not open window");

  cov_watchdog_expiry: cover property (terminal);
  cov_mode_write_taken: cover property (modeWrite);
  cov_stop_recovery: cover property (stopRecovered ##1 windowReg == WIN_ARMED);
  cov_window_closes: cover property (windowReg == WIN_OPEN ##1 windowReg == WIN_CLOSED);
  cov_halt_suspended: cover property (suspended && runningReg);
endmodule

//--- bench/core_model.sv
/*
  processor core model: turns bench commands into refresh and first-instruction
  pulses, a halt level, and a stop level that is masked while lowVoltageDetectEnable is high.
  assumes commands change just after rising edges of sys_clk.
*/
`timescale 1ns/10ps
module core_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic doRefresh,
  input wire logic doFirst,
  input wire logic doHalt,
  input wire logic doStop,
  input wire logic lowVoltageDetectEnable,
  output logic refreshPulse,
  output logic firstInstruction,
  output logic haltMode,
  output logic stopMode
);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      refreshPulse <= 1'b0;
      firstInstruction <= 1'b0;
      haltMode <= 1'b0;
      stopMode <= 1'b0;
    end else begin
      refreshPulse <= doRefresh;
      firstInstruction <= doFirst;
      haltMode <= doHalt;
      stopMode <= doStop & ~lowVoltageDetectEnable;
    end
  end
endmodule

//--- bench/watchdog_and_stop_recovery_reset_tb.sv
/*
  self-checking bench: read data and expiry times are queued by the driver and
  checked by a monitor. assumes a shortened rc tick and a shortened top rc tap.
*/
`timescale 1ns/10ps
module watchdog_and_stop_recovery_reset_tb;
  import watchdog_pkg::*;
  logic sys_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, refreshPulse, firstInstruction;
  logic haltMode, stopMode, doRefresh, doFirst, doHalt, doStop, stopRecovered;
  logic clrOne_n, clrTwo_n, lowVoltage, globalReset_n, expired, lvEn;
  logic levelHigh, delayBit, div16;
  logic [1:0] xdiv;
  logic [2:0] recSrc;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, r;
  logic [31:0] rq[$];
  int tq[$];
  int errCount = 0;
  int nTests = 0;
  int since = 0;
  int lim[8] = '{RC_TICKS0, RC_TICKS1, RC_TICKS2, 80, XTAL_TICKS0, XTAL_TICKS1, XTAL_TICKS2,
    XTAL_TICKS3};
  logic [31:0] seed = 32'h41;

  watchdog_stop_recovery #(.RcTickCycles(4),
    .RcTicks3(80)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .refreshPulse(refreshPulse),
    .firstInstruction(firstInstruction), .haltMode(haltMode), .stopMode(stopMode),
    .stopRecovered(stopRecovered), .crystalInputPin(xdiv[1]), .clearPulseOne_n(clrOne_n),
    .clearPulseTwo_n(clrTwo_n), .lowVoltage(lowVoltage), .globalReset_n(globalReset_n),
    .watchdogExpired(expired), .lowVoltageDetectEnable(lvEn), .recoverySource(recSrc),
    .recoveryLevelHigh(levelHigh), .recoveryDelay(delayBit), .clockDivide16(div16));
  core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .doRefresh(doRefresh),
    .doFirst(doFirst), .doHalt(doHalt), .doStop(doStop), .lowVoltageDetectEnable(lvEn),
    .refreshPulse(refreshPulse), .firstInstruction(firstInstruction),
    .haltMode(haltMode), .stopMode(stopMode));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkTime(input int exp, input int got);
    nTests++;
    if (got < exp - 8 || got > exp + 8) begin
      errCount++;
      $display("MISMATCH expiry cycles expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic waitCycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [31:0] s;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    s = rnd();
    wbSel <= {s[3:1], 1'b1};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) chk("bus ack", 32'h1, 32'h0);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic pulse(input bit first);
    @(posedge sys_clk);
    if (first) doFirst <= 1'b1;
    else doRefresh <= 1'b1;
    @(posedge sys_clk);
    doFirst <= 1'b0;
    doRefresh <= 1'b0;
  endtask

  task automatic waitExpiry();
    int n;
    n = 0;
    while (tq.size() > 0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    waitCycles(25);
  endtask

  always @(posedge sys_clk) begin
    xdiv <= xdiv + 2'h1;
    since <= (refreshPulse === 1'b1) ? 0 : since + 1;
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (rq.size() > 0) chk("read data", rq.pop_front(), wbDatR);
      else chk("unexpected read", 32'h0, 32'h1);
    end
    if (expired === 1'b1) begin
      if (tq.size() > 0) chkTime(tq.pop_front(), since);
      else chk("unexpected expiry", 32'h0, 32'h1);
      chk("reset on expiry", 32'h0, {31'h0, globalReset_n});
    end
  end

  initial begin
    waitCycles(60000);
    errCount++;
    $display("MISMATCH run expected end seen timeout");
    summarize();
  end

  initial begin
    {reset_n, wbCyc, wbStb, wbWe, doRefresh, doFirst, doHalt, doStop} = 8'h00;
    {stopRecovered, lowVoltage, wbAdr, wbSel, wbDatW, xdiv} = 48'h0;
    {clrOne_n, clrTwo_n} = 2'b11;
    waitCycles(5);
    reset_n <= 1'b1;
    waitCycles(2);
    chk("idle reset", 32'h1, {31'h0, globalReset_n});
    rd(ADDR_WATCHDOG_MODE, 32'h0);
    rd(8'h80, 32'h0);
    rd(ADDR_STOP_RECOVERY, 32'h0);
    r = rnd();
    wb(1'b1, ADDR_STOP_RECOVERY, {24'h0, r[7:0]});
    waitCycles(1);
    chk("recovery fields", {26'h0, r[6:5], r[4:2], r[0]},
      {26'h0, levelHigh, delayBit, recSrc, div16});
    @(posedge sys_clk) stopRecovered <= 1'b1;
    @(posedge sys_clk) stopRecovered <= 1'b0;
    rd(ADDR_STOP_RECOVERY, 32'h80);
    tq.push_back(RC_TICKS1 * 4);
    pulse(0);
    waitCycles(25);
    pulse(0);
    waitExpiry();
    pulse(1);
    waitCycles(2);
    wb(1'b1, ADDR_WATCHDOG_MODE, 32'h0);
    tq.push_back(RC_TICKS0 * 4 + 60);
    @(posedge sys_clk) doHalt <= 1'b1;
    pulse(0);
    waitCycles(30);
    doHalt <= 1'b0;
    doStop <= 1'b1;
    waitCycles(30);
    doStop <= 1'b0;
    waitExpiry();
    for (int i = 0; i < 8; i++) begin
      pulse(1);
      waitCycles(2);
      wb(1'b1, ADDR_WATCHDOG_MODE, {24'h0, 3'h7, i[2], 2'h3, i[1:0]});
      waitCycles(70);
      wb(1'b1, ADDR_WATCHDOG_MODE, {24'h0, 3'h0, ~i[2], 2'h3, ~i[1:0]});
      tq.push_back(lim[i] * 4);
      pulse(0);
      waitExpiry();
    end
    wb(1'b1, ADDR_LOW_VOLTAGE_CONTROL, 32'h1);
    lowVoltage <= 1'b1;
    waitCycles(3);
    chk("low supply reset", 32'h0, {31'h0, globalReset_n});
    rd(ADDR_BLOCK_STATUS, 32'h0);
    lowVoltage <= 1'b0;
    waitCycles(25);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) clrOne_n <= 1'b0;
      else clrTwo_n <= 1'b0;
      waitCycles(2);
      {clrOne_n, clrTwo_n} <= 2'b11;
      waitCycles(3);
      chk("clear reset", 32'h0, {31'h0, globalReset_n});
      waitCycles(25);
      chk("clear reset end", 32'h1, {31'h0, globalReset_n});
    end
    summarize();
  end
endmodule
